//--- rtl/aach_cmd_handler.sv
module aach_cmd_handler (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [15:0] rdata_o,
   output logic intrq_o,
   input wire logic dev_slave_i,
   input wire logic pm_standby_i,
   input wire logic cache_sup_i,
   output logic flush_req_o,
   input wire logic flush_done_i,
   output logic diag_req_o,
   input wire logic diag_done_i,
   input wire logic [3:0] diag_fail_i,
   input wire logic slave_fail_i,
   output logic erase_req_o,
   output logic [27:0] erase_addr_o,
   output logic erase_lba_o,
   input wire logic erase_ack_i,
   input wire logic erase_fault_i,
   input wire logic [27:0] lba_total_i
);
   aach_pkg::aach_state_t state_reg;
   logic [7:0] cmd_reg;
   logic [7:0] feat_reg;
   logic [7:0] scnt_reg;
   logic [7:0] snum_reg;
   logic [7:0] cyll_reg;
   logic [7:0] cylh_reg;
   logic [7:0] drvhd_reg;
   logic [7:0] err_reg;
   logic df_reg;
   logic errbit_reg;
   logic [7:0] word_idx_reg;
   logic [2:0] int_sts_reg;
   logic [2:0] int_sts_next;
   logic [2:0] int_msk_reg;
   logic [15:0] rdata_reg;
   logic flush_req_reg;
   logic diag_req_reg;
   logic erase_start;
   logic erase_done;
   logic erase_fault;
   logic [15:0] ident_word;
   logic busy;
   logic drq;
   logic cmd_wr;
   logic cmd_accept;
   logic data_rd;
   logic finish_ok;
   logic abort;
   logic [7:0] status;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] diag_code(input logic [3:0] fail);
      logic [7:0] code;
      code = aach_pkg::DIAG_OK;
      if (fail[0]) begin
         code = aach_pkg::DIAG_FMT;
      end else if (fail[1]) begin
         code = aach_pkg::DIAG_BUF;
      end else if (fail[2]) begin
         code = aach_pkg::DIAG_ECC;
      end else if (fail[3]) begin
         code = aach_pkg::DIAG_CPU;
      end
      return code;
   endfunction

   function automatic logic is_pm(input logic [7:0] c);
      return (c == aach_pkg::CMD_PM_A) || (c == aach_pkg::CMD_PM_B);
   endfunction

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign busy = (state_reg != aach_pkg::ST_IDLE) && (state_reg != aach_pkg::ST_XFER);
   assign drq = (state_reg == aach_pkg::ST_XFER);
   assign cmd_wr = we_i && (addr_i == aach_pkg::A_CMD);
   // the other drive's commands pass by; diagnostic is taken by both
   assign cmd_accept = cmd_wr && (state_reg == aach_pkg::ST_IDLE) &&
      ((drvhd_reg[aach_pkg::DH_DRV] == dev_slave_i) || (wdata_i[7:0] == aach_pkg::CMD_DIAG));
   assign data_rd = re_i && drq && (addr_i == aach_pkg::A_DATA);
   assign abort = (state_reg == aach_pkg::ST_DECODE) && !is_pm(cmd_reg) &&
      (cmd_reg != aach_pkg::CMD_ERASE) && (cmd_reg != aach_pkg::CMD_DIAG) &&
      (cmd_reg != aach_pkg::CMD_IDENT) &&
      ((cmd_reg != aach_pkg::CMD_FLUSH) || !cache_sup_i);
   assign finish_ok = (state_reg == aach_pkg::ST_FINISH);

   // ----------------------------------------
   // command sequencer
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= aach_pkg::ST_IDLE;
         cmd_reg <= aach_pkg::TF_RESET;
      end else begin
         case (state_reg)
            aach_pkg::ST_IDLE: begin
               if (cmd_accept) begin
                  cmd_reg <= wdata_i[7:0];
                  state_reg <= aach_pkg::ST_DECODE;
               end
            end
            aach_pkg::ST_DECODE: begin
               if (is_pm(cmd_reg) || abort) begin
                  state_reg <= aach_pkg::ST_FINISH;
               end else if (cmd_reg == aach_pkg::CMD_IDENT) begin
                  state_reg <= aach_pkg::ST_XFER;
               end else begin
                  state_reg <= aach_pkg::ST_RUN;
               end
            end
            aach_pkg::ST_RUN: begin
               // busy stays up until the engine behind the command reports back
               if ((cmd_reg == aach_pkg::CMD_ERASE && erase_done) ||
                   (cmd_reg == aach_pkg::CMD_DIAG && diag_done_i) ||
                   (cmd_reg == aach_pkg::CMD_FLUSH && flush_done_i)) begin
                  state_reg <= aach_pkg::ST_FINISH;
               end
            end
            aach_pkg::ST_FINISH: begin
               state_reg <= aach_pkg::ST_IDLE;
            end
            aach_pkg::ST_XFER: begin
               if (data_rd && word_idx_reg == aach_pkg::IDENT_LAST) begin
                  state_reg <= aach_pkg::ST_IDLE;
               end
            end
            default: begin
               state_reg <= aach_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // task file
   // ----------------------------------------
   // writes while busy are dropped so a running command keeps its parameters
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         feat_reg <= aach_pkg::TF_RESET;
         snum_reg <= aach_pkg::TF_RESET;
         cyll_reg <= aach_pkg::TF_RESET;
         cylh_reg <= aach_pkg::TF_RESET;
         drvhd_reg <= aach_pkg::TF_RESET;
      end else if (we_i && !busy) begin
         case (addr_i)
            aach_pkg::A_FEAT: feat_reg <= wdata_i[7:0];
            aach_pkg::A_SNUM: snum_reg <= wdata_i[7:0];
            aach_pkg::A_CYLL: cyll_reg <= wdata_i[7:0];
            aach_pkg::A_CYLH: cylh_reg <= wdata_i[7:0];
            aach_pkg::A_DRVHD: drvhd_reg <= wdata_i[7:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         scnt_reg <= aach_pkg::SCNT_RESET;
      end else if (state_reg == aach_pkg::ST_DECODE && is_pm(cmd_reg)) begin
         scnt_reg <= pm_standby_i ? aach_pkg::PM_STANDBY : aach_pkg::PM_IDLE;
      end else if (we_i && !busy && addr_i == aach_pkg::A_SCNT) begin
         scnt_reg <= wdata_i[7:0];
      end
   end

   // ----------------------------------------
   // error and fault results
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         err_reg <= aach_pkg::TF_RESET;
         errbit_reg <= 1'b0;
         df_reg <= 1'b0;
      end else if (cmd_accept) begin
         err_reg <= aach_pkg::TF_RESET;
         errbit_reg <= 1'b0;
         df_reg <= 1'b0;
      end else if (abort) begin
         err_reg[aach_pkg::ER_ABRT] <= 1'b1;
         errbit_reg <= 1'b1;
      end else if (state_reg == aach_pkg::ST_RUN && cmd_reg == aach_pkg::CMD_DIAG && diag_done_i) begin
         err_reg <= diag_code(diag_fail_i);
         // only the master folds in the slave's outcome
         if (!dev_slave_i) begin
            err_reg[aach_pkg::ER_SLAVE] <= slave_fail_i;
         end
      end else if (erase_done && erase_fault) begin
         df_reg <= 1'b1;
         errbit_reg <= 1'b1;
      end
   end

   // ----------------------------------------
   // engines
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         flush_req_reg <= 1'b0;
         diag_req_reg <= 1'b0;
      end else begin
         flush_req_reg <= (state_reg == aach_pkg::ST_DECODE) &&
            (cmd_reg == aach_pkg::CMD_FLUSH) && cache_sup_i;
         diag_req_reg <= (state_reg == aach_pkg::ST_DECODE) &&
            (cmd_reg == aach_pkg::CMD_DIAG);
      end
   end

   assign flush_req_o = flush_req_reg;
   assign diag_req_o = diag_req_reg;
   assign erase_start = (state_reg == aach_pkg::ST_DECODE) && (cmd_reg == aach_pkg::CMD_ERASE);
   assign erase_lba_o = drvhd_reg[aach_pkg::DH_LBA];

   aach_erase_seq u_erase (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .start_i(erase_start),
      .first_addr_i({drvhd_reg[3:0], cylh_reg, cyll_reg, snum_reg}),
      .count_i(scnt_reg),
      .ack_i(erase_ack_i),
      .fault_i(erase_fault_i),
      .req_o(erase_req_o),
      .addr_o(erase_addr_o),
      .done_o(erase_done),
      .fault_o(erase_fault)
   );

   // ----------------------------------------
   // identify data
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         word_idx_reg <= 8'h00;
      end else if (state_reg == aach_pkg::ST_DECODE) begin
         word_idx_reg <= 8'h00;
      end else if (data_rd) begin
         word_idx_reg <= word_idx_reg + 8'h01;
      end
   end

   aach_ident_rom u_ident (
      .word_idx_i(word_idx_reg),
      .lba_total_i(lba_total_i),
      .word_o(ident_word)
   );

   // ----------------------------------------
   // interrupt
   // ----------------------------------------
   // raised on the same edge that drops busy, so results are already stable
   always_comb begin
      int_sts_next = 3'h0;
      int_sts_next[aach_pkg::INT_DONE] = finish_ok;
      int_sts_next[aach_pkg::INT_DRQ] = (state_reg == aach_pkg::ST_DECODE) &&
         (cmd_reg == aach_pkg::CMD_IDENT);
      int_sts_next[aach_pkg::INT_ERR] = finish_ok && (errbit_reg || df_reg);
   end

   // a new event in the clearing read's cycle survives
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         int_sts_reg <= aach_pkg::INT_RESET;
      end else if (re_i && addr_i == aach_pkg::A_INT_STS) begin
         int_sts_reg <= int_sts_next;
      end else begin
         int_sts_reg <= int_sts_reg | int_sts_next;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         int_msk_reg <= aach_pkg::INT_RESET;
      end else if (we_i && addr_i == aach_pkg::A_INT_MSK) begin
         int_msk_reg <= wdata_i[2:0];
      end
   end

   assign intrq_o = |(int_sts_reg & int_msk_reg);

   // ----------------------------------------
   // read back
   // ----------------------------------------
   always_comb begin
      status = 8'h00;
      status[aach_pkg::ST_BSY] = busy;
      status[aach_pkg::ST_DRDY] = !busy;
      status[aach_pkg::ST_DSC] = !busy;
      status[aach_pkg::ST_DF] = df_reg;
      status[aach_pkg::ST_DRQ] = drq;
      status[aach_pkg::ST_ERR] = errbit_reg;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_reg <= 16'h0000;
      end else if (re_i) begin
         case (addr_i)
            aach_pkg::A_DATA: rdata_reg <= drq ? ident_word : 16'h0000;
            aach_pkg::A_FEAT: rdata_reg <= {8'h00, feat_reg};
            aach_pkg::A_SCNT: rdata_reg <= {8'h00, scnt_reg};
            aach_pkg::A_SNUM: rdata_reg <= {8'h00, snum_reg};
            aach_pkg::A_CYLL: rdata_reg <= {8'h00, cyll_reg};
            aach_pkg::A_CYLH: rdata_reg <= {8'h00, cylh_reg};
            aach_pkg::A_DRVHD: rdata_reg <= {8'h00, drvhd_reg};
            aach_pkg::A_CMD: rdata_reg <= {8'h00, status};
            aach_pkg::A_ERR: rdata_reg <= {8'h00, err_reg};
            aach_pkg::A_INT_STS: rdata_reg <= {13'h0, int_sts_reg};
            aach_pkg::A_INT_MSK: rdata_reg <= {13'h0, int_msk_reg};
            default: rdata_reg <= 16'h0000;
         endcase
      end else begin
         rdata_reg <= 16'h0000;
      end
   end

   assign rdata_o = rdata_reg;
endmodule

//--- common/aach_pkg.sv
package aach_pkg;
   // -----------------------------------------
   // register offsets
   // -----------------------------------------
   localparam logic [3:0] A_DATA = 4'h0;
   localparam logic [3:0] A_FEAT = 4'h1;
   localparam logic [3:0] A_SCNT = 4'h2;
   localparam logic [3:0] A_SNUM = 4'h3;
   localparam logic [3:0] A_CYLL = 4'h4;
   localparam logic [3:0] A_CYLH = 4'h5;
   localparam logic [3:0] A_DRVHD = 4'h6;
   localparam logic [3:0] A_CMD = 4'h7;
   localparam logic [3:0] A_ERR = 4'h8;
   localparam logic [3:0] A_INT_STS = 4'h9;
   localparam logic [3:0] A_INT_MSK = 4'ha;
   // -----------------------------------------
   // command codes
   // -----------------------------------------
   localparam logic [7:0] CMD_PM_A = 8'h98;
   localparam logic [7:0] CMD_PM_B = 8'he5;
   localparam logic [7:0] CMD_ERASE = 8'hc0;
   localparam logic [7:0] CMD_DIAG = 8'h90;
   localparam logic [7:0] CMD_FLUSH = 8'he7;
   localparam logic [7:0] CMD_IDENT = 8'hec;
   // -----------------------------------------
   // result values
   // -----------------------------------------
   localparam logic [7:0] PM_STANDBY = 8'h00;
   localparam logic [7:0] PM_IDLE = 8'hff;
   localparam logic [7:0] DIAG_OK = 8'h01;
   localparam logic [7:0] DIAG_FMT = 8'h02;
   localparam logic [7:0] DIAG_BUF = 8'h03;
   localparam logic [7:0] DIAG_ECC = 8'h04;
   localparam logic [7:0] DIAG_CPU = 8'h05;
   // -----------------------------------------
   // field positions
   // -----------------------------------------
   localparam int ST_BSY = 7;
   localparam int ST_DRDY = 6;
   localparam int ST_DF = 5;
   localparam int ST_DSC = 4;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   localparam int ER_ABRT = 2;
   localparam int ER_SLAVE = 7;
   localparam int DH_LBA = 6;
   localparam int DH_DRV = 4;
   localparam int INT_DONE = 0;
   localparam int INT_DRQ = 1;
   localparam int INT_ERR = 2;
   // -----------------------------------------
   // reset values and counts
   // -----------------------------------------
   localparam logic [7:0] TF_RESET = 8'h00;
   localparam logic [7:0] SCNT_RESET = 8'h01;
   localparam logic [2:0] INT_RESET = 3'h0;
   localparam logic [7:0] IDENT_LAST = 8'hff;
   localparam logic [8:0] ERASE_FULL = 9'h100;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DECODE = 3'b001,
      ST_RUN = 3'b011,
      ST_FINISH = 3'b010,
      ST_XFER = 3'b110
   } aach_state_t;
endpackage

//--- rtl/aach_ident_rom.sv
module aach_ident_rom (
   input wire logic [7:0] word_idx_i,
   input wire logic [27:0] lba_total_i,
   output logic [15:0] word_o
);
   localparam logic [15:0] W_CONFIG = 16'h044a;
   localparam logic [15:0] W_BUFTYPE = 16'h0002;
   localparam logic [15:0] W_BUFSIZE = 16'h0002;
   localparam logic [15:0] W_MULT = 16'h8001;
   localparam logic [15:0] W_CAP = 16'h0f00;
   localparam logic [15:0] W_CAP2 = 16'h4000;
   localparam logic [15:0] W_PIO = 16'h0200;
   localparam logic [15:0] W_VALID = 16'h0007;
   localparam logic [15:0] W_APIO = 16'h0003;
   localparam logic [15:0] W_CYCLE = 16'h0078;
   localparam logic [15:0] W_SATACAP = 16'h0006;
   localparam logic [15:0] W_SATAFEAT = 16'h0008;
   localparam logic [15:0] W_VERSION = 16'h0080;

   // anything not listed reads zero, so reserved words and bits stay clear
   always_comb begin
      case (word_idx_i)
         8'h00: word_o = W_CONFIG;
         8'h07: word_o = {4'h0, lba_total_i[27:16]};
         8'h08: word_o = lba_total_i[15:0];
         8'h14: word_o = W_BUFTYPE;
         8'h15: word_o = W_BUFSIZE;
         8'h2f: word_o = W_MULT;
         8'h31: word_o = W_CAP;
         8'h32: word_o = W_CAP2;
         8'h33: word_o = W_PIO;
         8'h35: word_o = W_VALID;
         8'h3c: word_o = lba_total_i[15:0];
         8'h3d: word_o = {4'h0, lba_total_i[27:16]};
         8'h40: word_o = W_APIO;
         8'h41, 8'h42, 8'h43, 8'h44: word_o = W_CYCLE;
         8'h4c: word_o = W_SATACAP;
         8'h4e: word_o = W_SATAFEAT;
         8'h50: word_o = W_VERSION;
         default: word_o = 16'h0000;
      endcase
   end
endmodule

//--- rtl/aach_erase_seq.sv
module aach_erase_seq (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [27:0] first_addr_i,
   input wire logic [7:0] count_i,
   input wire logic ack_i,
   input wire logic fault_i,
   output logic req_o,
   output logic [27:0] addr_o,
   output logic done_o,
   output logic fault_o
);
   logic active_reg;
   logic [8:0] remain_reg;
   logic [27:0] addr_reg;
   logic done_reg;
   logic fault_reg;

   // ----------------------------------------
   // sector walk
   // ----------------------------------------
   // a count of zero means the full 256 sectors
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         active_reg <= 1'b0;
         remain_reg <= 9'h000;
         addr_reg <= 28'h0000000;
         done_reg <= 1'b0;
         fault_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (start_i) begin
            active_reg <= 1'b1;
            addr_reg <= first_addr_i;
            remain_reg <= (count_i == 8'h00) ? aach_pkg::ERASE_FULL : {1'b0, count_i};
            fault_reg <= 1'b0;
         end else if (active_reg && ack_i) begin
            addr_reg <= addr_reg + 28'h0000001;
            remain_reg <= remain_reg - 9'h001;
            // a fault stops the walk so the host sees it at once
            if (fault_i || remain_reg == 9'h001) begin
               active_reg <= 1'b0;
               done_reg <= 1'b1;
               fault_reg <= fault_i;
            end
         end
      end
   end

   assign req_o = active_reg;
   assign addr_o = addr_reg;
   assign done_o = done_reg;
   assign fault_o = fault_reg;
endmodule

//--- test/aach_checker.sv
module aach_checker (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   input wire logic [15:0] rdata_o,
   input wire logic intrq_o,
   input wire logic cache_sup_i,
   input wire logic flush_req_o,
   input wire logic diag_req_o,
   input wire logic erase_req_o,
   input wire logic [27:0] erase_addr_o,
   input wire logic erase_ack_i,
   input wire logic erase_fault_i
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   // ------------------------------
   // requests follow their command write
   // ------------------------------
   property p_flush_cause;
      $rose(flush_req_o) |-> $past(we_i, 2) && cache_sup_i && $past(addr_i, 2) == aach_pkg::A_CMD
         && $past(wdata_i, 2) == {8'h00, aach_pkg::CMD_FLUSH};
   endproperty
   a_flush_cause: assert property (p_flush_cause) else $error("flush start without command");
   property p_flush_pulse;
      flush_req_o |=> !flush_req_o;
   endproperty
   a_flush_pulse: assert property (p_flush_pulse) else $error("flush request too long");
   property p_diag_cause;
      $rose(diag_req_o) |-> $past(we_i, 2) && $past(wdata_i, 2) == {8'h00, aach_pkg::CMD_DIAG};
   endproperty
   a_diag_cause: assert property (p_diag_cause) else $error("self-test without command");
   property p_diag_pulse;
      diag_req_o |=> !diag_req_o;
   endproperty
   a_diag_pulse: assert property (p_diag_pulse) else $error("self-test request too long");
   property p_erase_cause;
      $rose(erase_req_o) |-> $past(erase_req_o, 2)
         || ($past(we_i, 2) && $past(wdata_i, 2) == {8'h00, aach_pkg::CMD_ERASE});
   endproperty
   a_erase_cause: assert property (p_erase_cause) else $error("erase without command");
   // next sector after a clean acknowledge while the request stays up
   property p_erase_step;
      erase_req_o && erase_ack_i && !erase_fault_i ##1 erase_req_o |-> erase_addr_o == $past(erase_addr_o) + 28'h1;
   endproperty
   a_erase_step: assert property (p_erase_step) else $error("erase address did not step");
   property p_rd_idle;
      !$past(re_i) |-> rdata_o == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_one_job;
      erase_req_o |-> !flush_req_o && !diag_req_o;
   endproperty
   a_one_job: assert property (p_one_job) else $error("two jobs at once");
   c_flush: cover property (flush_req_o);
   c_diag: cover property (diag_req_o);
   c_erase: cover property (erase_req_o && erase_ack_i && erase_fault_i);
   c_int: cover property ($rose(intrq_o));
endmodule

bind aach_cmd_handler aach_checker u_chk (.clk_sys_i, .rst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
   .intrq_o, .cache_sup_i, .flush_req_o, .diag_req_o, .erase_req_o, .erase_addr_o, .erase_ack_i, .erase_fault_i);

//--- test/aach_media_model.sv
module aach_media_model (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic flush_req_i,
   input wire logic diag_req_i,
   input wire logic erase_req_i,
   input wire logic [7:0] lat_i,
   input wire logic [7:0] fault_at_i,
   output logic flush_done_o,
   output logic diag_done_o,
   output logic erase_ack_o,
   output logic erase_fault_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic is_diag;
   logic [8:0] n = 9'h000;
   logic [7:0] gap = 8'h00;
   // ------------------------------
   // cache flush, self-test and erase back end
   // ------------------------------
   initial begin
      flush_done_o = 1'b0;
      diag_done_o = 1'b0;
      erase_ack_o = 1'b0;
      erase_fault_o = 1'b0;
   end
   always begin
      @(posedge clk_sys_i);
      if (!rst_i && (flush_req_i || diag_req_i)) begin
         is_diag = diag_req_i;
         repeat (lat_i) @(posedge clk_sys_i);
         flush_done_o <= !is_diag;
         diag_done_o <= is_diag;
         @(posedge clk_sys_i);
         flush_done_o <= 1'b0;
         diag_done_o <= 1'b0;
      end
   end
   // sector count survives a one-cycle drop of the request between sectors
   always begin
      @(posedge clk_sys_i);
      if (rst_i || !erase_req_i) begin
         gap = gap + 8'h01;
         if (gap > 8'h03)
            n = 9'h000;
      end else begin
         gap = 8'h00;
         repeat (lat_i) @(posedge clk_sys_i);
         n = n + 9'h001;
         erase_ack_o <= 1'b1;
         erase_fault_o <= (n == {1'b0, fault_at_i});
         @(posedge clk_sys_i);
         erase_ack_o <= 1'b0;
         erase_fault_o <= 1'b0;
      end
   end
endmodule

//--- test/aach_cmd_handler_tb_top.sv
module aach_cmd_handler_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i, rst_i, we_i, re_i, dev_slave_i, pm_standby_i, cache_sup_i, slave_fail_i, re_d;
   logic intrq_o, flush_req_o, flush_done_i, diag_req_o, diag_done_i, erase_req_o, erase_lba_o;
   logic erase_ack_i, erase_fault_i;
   logic [3:0] addr_i, diag_fail_i;
   logic [15:0] wdata_i, rdata_o;
   logic [27:0] erase_addr_o, lba_total_i, base;
   logic [7:0] lat, fault_at;
   logic [31:0] rd_q[$];
   logic [28:0] ea_q[$];
   int failures, samples_checked, cnt, n;
   aach_cmd_handler dut (.clk_sys_i, .rst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .intrq_o, .dev_slave_i,
      .pm_standby_i, .cache_sup_i, .flush_req_o, .flush_done_i, .diag_req_o, .diag_done_i, .diag_fail_i,
      .slave_fail_i, .erase_req_o, .erase_addr_o, .erase_lba_o, .erase_ack_i, .erase_fault_i, .lba_total_i);
   aach_media_model u_media (.clk_sys_i, .rst_i, .flush_req_i(flush_req_o), .diag_req_i(diag_req_o),
      .erase_req_i(erase_req_o), .lat_i(lat), .fault_at_i(fault_at), .flush_done_o(flush_done_i),
      .diag_done_o(diag_done_i), .erase_ack_o(erase_ack_i), .erase_fault_o(erase_fault_i));
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   // ------------------------------
   // compare and bus tasks
   // ------------------------------
   task automatic note(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_rd(input logic [15:0] got, input logic [31:0] e);
      note({16'h0000, got & e[31:16]}, {16'h0000, e[15:0]});
   endtask
   task automatic chk_ea(input logic [28:0] got, input logic [28:0] exp);
      note({3'h0, got}, {3'h0, exp});
   endtask
   task automatic chk_int(input logic got, input logic exp);
      note({31'h0, got}, {31'h0, exp});
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      addr_i <= a;
      wdata_i <= d;
      we_i <= 1'b1;
      re_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   // mask picks the bits that are defined for this read
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
      addr_i <= a;
      re_i <= 1'b1;
      we_i <= 1'b0;
      rd_q.push_back({m, e & m});
      @(posedge clk_sys_i);
   endtask
   task automatic cyc(input int k);
      we_i <= 1'b0;
      re_i <= 1'b0;
      repeat (k) @(posedge clk_sys_i);
   endtask
   task automatic wait_int;
      cnt = 0;
      cyc(1);
      while (intrq_o !== 1'b1 && cnt < 3000) begin
         cyc(1);
         cnt++;
      end
      if (cnt == 3000)
         failures++;
   endtask
   task automatic end_of_test;
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      if (re_d)
         chk_rd(rdata_o, rd_q.pop_front());
      re_d <= re_i && !rst_i;
      if (erase_req_o && erase_ack_i)
         chk_ea({erase_lba_o, erase_addr_o}, ea_q.pop_front());
   end
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      failures++;
      end_of_test;
   end
   // ------------------------------
   // scenarios
   // ------------------------------
   initial begin
      failures = 0;
      samples_checked = 0;
      cnt = $urandom(32'hba2d0ec1);
      rst_i = 1'b1;
      we_i = 1'b0;
      re_i = 1'b0;
      re_d = 1'b0;
      addr_i = 4'h0;
      wdata_i = 16'h0000;
      dev_slave_i = 1'b0;
      pm_standby_i = 1'b0;
      cache_sup_i = 1'b1;
      diag_fail_i = 4'h0;
      slave_fail_i = 1'b0;
      fault_at = 8'h00;
      lat = 8'($urandom_range(3));
      lba_total_i = 28'($urandom);
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rd(aach_pkg::A_CMD, 16'h0050);
      rd(aach_pkg::A_SCNT, 16'h0001);
      rd(aach_pkg::A_INT_MSK, 16'h0000);
      rd(4'hf, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         pm_standby_i <= i[0];
         wr(aach_pkg::A_INT_MSK, 16'h0000);
         wr(aach_pkg::A_SCNT, 16'($urandom));
         wr(aach_pkg::A_CMD, i[1] ? 16'h0098 : 16'h00e5);
         cyc(4);
         chk_int(intrq_o, 1'b0);
         wr(aach_pkg::A_INT_MSK, 16'h0007);
         cyc(1);
         chk_int(intrq_o, 1'b1);
         rd(aach_pkg::A_SCNT, i[0] ? 16'h0000 : 16'h00ff);
         rd(aach_pkg::A_INT_STS, 16'h0001);
         rd(aach_pkg::A_INT_STS, 16'h0000);
         cyc(1);
         chk_int(intrq_o, 1'b0);
      end
      // other drive selected: command must be dropped
      wr(aach_pkg::A_DRVHD, 16'h0010);
      wr(aach_pkg::A_CMD, 16'h00e7);
      cyc(4);
      rd(aach_pkg::A_INT_STS, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         diag_fail_i <= (i == 0 || i == 5) ? 4'h0 : 4'($urandom << i) | 4'(1 << (i - 1));
         slave_fail_i <= (i >= 4);
         dev_slave_i <= (i == 4);
         wr(aach_pkg::A_CMD, 16'h0090);
         wait_int;
         rd(aach_pkg::A_ERR, (i == 5) ? 16'h0081 : 16'(i + 1));
         rd(aach_pkg::A_INT_STS, 16'h0001);
      end
      wr(aach_pkg::A_DRVHD, 16'h0000);
      for (int i = 0; i < 2; i++) begin
         cache_sup_i <= (i == 0);
         wr(aach_pkg::A_CMD, 16'h00e7);
         rd(aach_pkg::A_CMD, 16'h0080);
         wait_int;
         rd(aach_pkg::A_CMD, i ? 16'h0051 : 16'h0050);
         rd(aach_pkg::A_ERR, i ? 16'h0004 : 16'h0000);
         rd(aach_pkg::A_INT_STS, i ? 16'h0005 : 16'h0001);
      end
      // clean run, fault on second sector, count zero meaning 256
      for (int i = 0; i < 3; i++) begin
         base = 28'($urandom);
         n = (i == 2) ? 0 : i + 3;
         fault_at <= (i == 1) ? 8'h02 : 8'h00;
         wr(aach_pkg::A_SNUM, {8'h00, base[7:0]});
         wr(aach_pkg::A_CYLL, {8'h00, base[15:8]});
         wr(aach_pkg::A_CYLH, {8'h00, base[23:16]});
         wr(aach_pkg::A_DRVHD, {8'h00, (i == 0) ? 4'ha : 4'he, base[27:24]});
         wr(aach_pkg::A_SCNT, 16'(n));
         wr(aach_pkg::A_CMD, 16'h00c0);
         for (int k = 0; k < ((i == 1) ? 2 : (n == 0 ? 256 : n)); k++)
            ea_q.push_back({(i != 0), base + 28'(k)});
         wait_int;
         rd(aach_pkg::A_INT_STS, (i == 1) ? 16'h0005 : 16'h0001);
         rd(aach_pkg::A_CMD, (i == 1) ? 16'h0071 : 16'h0050);
         chk_ea(29'(ea_q.size()), 29'h0);
      end
      wr(aach_pkg::A_CMD, 16'h00ec);
      cyc(3);
      chk_int(intrq_o, 1'b1);
      rd(aach_pkg::A_CMD, 16'h0058);
      rd(aach_pkg::A_INT_STS, 16'h0002);
      for (int w = 0; w < 256; w++)
         rd(aach_pkg::A_DATA, 16'h0000, (w == 2 || (w >= 69 && w <= 75) || w == 77) ? 16'hffff : 16'h0000);
      rd(aach_pkg::A_CMD, 16'h0050);
      rd(aach_pkg::A_DATA, 16'h0000);
      cyc(3);
      end_of_test;
   end
endmodule
